// [design/tmz_consts.vh]
/*
 * Constants for the prescaled timer block: register offsets, field
 * positions, reset values and widths.
 * Assumes it is included by bare name from the design files only.
 */
// Operation
// (RL1) sixteen-bit count held as separately read and written high and low bytes
// (RL2) eight-bit prescaler ahead of the count gives 24-bit overflow range
// (RL3) source select one counts instruction clocks, zero counts the count pin
// (RL4) count pin edge select one counts rising edges, zero falling edges
// (RL5) qualifying pin edges raise pin flag; internal source ignores edge select
// (RL6) prescale codes 0000..0111 divide 1..128, top bit set divides 256
// (RL7) interrupt pin edge select one means rising, zero means falling
// (RL8) control bit zero is unimplemented and always reads zero
// (RL9) count advances per prescaler pulse, carries, wrap sets overflow flag
`ifndef TMZ_CONSTS_VH
`define TMZ_CONSTS_VH

// register offsets on the plain register port
`define TMZ_ADDR_W 8
`define TMZ_ADDR_CTRL 8'h05
`define TMZ_ADDR_CNT_LO 8'h0b
`define TMZ_ADDR_CNT_HI 8'h0c
`define TMZ_ADDR_STAT 8'h10
`define TMZ_ADDR_MASK 8'h11

// control register fields
`define TMZ_CTRL_INT_EDGE 7
`define TMZ_CTRL_CNT_EDGE 6
`define TMZ_CTRL_SRC 5
`define TMZ_CTRL_PS_HI 4
`define TMZ_CTRL_PS_LO 1
`define TMZ_CTRL_RST 8'h00
`define TMZ_CTRL_WMASK 8'hfe

// status and mask register fields
`define TMZ_ST_OVF 0
`define TMZ_ST_CNT_PIN 1
`define TMZ_ST_INT_PIN 2
`define TMZ_ST_WMASK 8'h07
`define TMZ_ST_RST 8'h00

// widths and count reset
`define TMZ_DATA_W 8
`define TMZ_CNT_W 16
`define TMZ_PRE_W 8
`define TMZ_CNT_RST 16'h0000
`define TMZ_CNT_ALL1 16'hffff
`define TMZ_PRE_RST 8'h00

`endif

// [design/tmz_pin_sync.v]
/*
 * Pin synchroniser with edge detection for the prescaled timer.
 * Assumes the pin is asynchronous to clk_i; two flip-flops settle it
 * before the edge detector looks at it.
 */
`timescale 1ns/100ps
`default_nettype none

module tmz_pin_sync (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // raw pin
    input wire pin_i,
    // synchronised level and one-cycle edge pulses
    output wire level_o,
    output wire rise_o,
    output wire fall_o
);

    reg meta_r;
    reg sync_r;
    reg prev_r;

    // first stage feeds only the second stage
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= pin_i;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // edges compare settled stages only
    assign level_o = sync_r;
    assign rise_o = sync_r & ~prev_r;
    assign fall_o = ~sync_r & prev_r;

endmodule // tmz_pin_sync

`default_nettype wire

// [design/tmz_timer0.v]
/*
 * Prescaled sixteen-bit timer/counter with control, count, status and
 * mask registers on a plain register port, and one level interrupt.
 * Assumes a single 100 MHz clock standing in for the instruction clock,
 * asynchronous pins on the count and interrupt inputs, and a register
 * master that never issues read and write strobes together.
 */
`timescale 1ns/100ps
`default_nettype none
`include "tmz_consts.vh"

module tmz_timer0 (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // register port
    input wire [`TMZ_ADDR_W-1:0] addr_i,
    input wire [`TMZ_DATA_W-1:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output wire [`TMZ_DATA_W-1:0] rdata_o,
    // external pins
    input wire count_input_pin_i,
    input wire external_interrupt_pin_i,
    // interrupt and status
    output wire irq_o,
    output wire overflow_o
);

    // decode of the prescale field into a low-bits mask
    function [`TMZ_PRE_W-1:0] ps_mask;
        input [3:0] code;
        begin
            if (code[3]) begin
                ps_mask = 8'hff;
            end else begin
                case (code[2:0])
                    3'd0: ps_mask = 8'h00;
                    3'd1: ps_mask = 8'h01;
                    3'd2: ps_mask = 8'h03;
                    3'd3: ps_mask = 8'h07;
                    3'd4: ps_mask = 8'h0f;
                    3'd5: ps_mask = 8'h1f;
                    3'd6: ps_mask = 8'h3f;
                    default: ps_mask = 8'h7f;
                endcase
            end
        end
    endfunction

    // address match used by both the write and read paths
    function hit;
        input [`TMZ_ADDR_W-1:0] a;
        input [`TMZ_ADDR_W-1:0] b;
        begin
            hit = (a == b);
        end
    endfunction

    // registers
    reg [`TMZ_DATA_W-1:0] ctrl_r;
    reg [`TMZ_DATA_W-1:0] ctrl_nxt;
    reg [`TMZ_CNT_W-1:0] main_count_r;
    reg [`TMZ_CNT_W-1:0] main_count_nxt;
    reg [`TMZ_PRE_W-1:0] pre_r;
    reg [`TMZ_PRE_W-1:0] pre_nxt;
    reg [`TMZ_DATA_W-1:0] stat_r;
    reg [`TMZ_DATA_W-1:0] stat_nxt;
    reg [`TMZ_DATA_W-1:0] mask_r;
    reg [`TMZ_DATA_W-1:0] mask_nxt;
    reg [`TMZ_DATA_W-1:0] rdata_r;
    reg [`TMZ_DATA_W-1:0] rdata_nxt;
    reg ovf_r;
    reg ovf_nxt;

    // decoded writes
    wire wr_ctrl;
    wire wr_lo;
    wire wr_hi;
    wire wr_stat;
    wire wr_mask;

    // pin events
    wire cnt_pin_lvl;
    wire cnt_pin_rise;
    wire cnt_pin_fall;
    wire int_pin_lvl;
    wire int_pin_rise;
    wire int_pin_fall;

    // control fields
    wire src_internal;
    wire cnt_edge_rising;
    wire int_edge_rising;
    wire [3:0] ps_code;
    wire [`TMZ_PRE_W-1:0] pre_mask;

    // chain events
    wire cnt_pin_evt;
    wire int_pin_evt;
    wire src_tick;
    wire pre_out;
    wire cnt_wrap;
    wire [`TMZ_DATA_W-1:0] set_bits;

    // count pin synchroniser
    tmz_pin_sync u_cnt_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(count_input_pin_i),
        .level_o(cnt_pin_lvl),
        .rise_o(cnt_pin_rise),
        .fall_o(cnt_pin_fall)
    );

    // interrupt pin synchroniser
    tmz_pin_sync u_int_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(external_interrupt_pin_i),
        .level_o(int_pin_lvl),
        .rise_o(int_pin_rise),
        .fall_o(int_pin_fall)
    );

    // write decode, one register per strobe
    assign wr_ctrl = wr_i & hit(addr_i, `TMZ_ADDR_CTRL);
    assign wr_lo = wr_i & hit(addr_i, `TMZ_ADDR_CNT_LO);
    assign wr_hi = wr_i & hit(addr_i, `TMZ_ADDR_CNT_HI);
    assign wr_stat = wr_i & hit(addr_i, `TMZ_ADDR_STAT);
    assign wr_mask = wr_i & hit(addr_i, `TMZ_ADDR_MASK);

    // control field extraction
    assign src_internal = ctrl_r[`TMZ_CTRL_SRC];
    assign cnt_edge_rising = ctrl_r[`TMZ_CTRL_CNT_EDGE];
    assign int_edge_rising = ctrl_r[`TMZ_CTRL_INT_EDGE];
    assign ps_code = ctrl_r[`TMZ_CTRL_PS_HI:`TMZ_CTRL_PS_LO];

    // (RL4) count pin edge
    assign cnt_pin_evt = cnt_edge_rising ? cnt_pin_rise : cnt_pin_fall;

    // (RL7) interrupt pin edge
    assign int_pin_evt = int_edge_rising ? int_pin_rise : int_pin_fall;

    // (RL3) count source choice
    // (RL5) internal ignores edge
    assign src_tick = src_internal ? 1'b1 : cnt_pin_evt;

    // (RL6) prescale ratio decode
    assign pre_mask = ps_mask(ps_code);

    // (RL2) prescaler output pulse
    // the pulse fires when the selected low bits are all ones
    assign pre_out = src_tick & ((pre_r & pre_mask) == pre_mask);

    // (RL9) wrap from all ones
    assign cnt_wrap = pre_out & (main_count_r == `TMZ_CNT_ALL1);

    // events collected into the status layout
    assign set_bits = {5'b0_0000, int_pin_evt, cnt_pin_evt, cnt_wrap};

    // control register, bit zero never stored
    always @* begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl) begin
            // (RL8) bit zero forced low
            ctrl_nxt = wdata_i & `TMZ_CTRL_WMASK;
        end
    end

    // prescaler runs free on source ticks
    // a count write or control write clears it so the next period is whole
    always @* begin
        pre_nxt = pre_r;
        if (wr_lo | wr_hi | wr_ctrl) begin
            pre_nxt = `TMZ_PRE_RST;
        end else if (src_tick) begin
            // (RL2) prescaler advances
            pre_nxt = pre_r + 8'h01;
        end
    end

    // main count; a software byte write wins over a tick for the byte written, the other byte still takes the tick
    always @* begin
        main_count_nxt = main_count_r;
        if (pre_out) begin
            // (RL9) carry into high byte
            main_count_nxt = main_count_r + 16'h0001;
        end
        // (RL1) separate byte writes
        if (wr_lo) begin
            main_count_nxt[7:0] = wdata_i;
        end
        if (wr_hi) begin
            main_count_nxt[15:8] = wdata_i;
        end
    end

    // sticky status: write one clears, a new event in the same cycle wins
    always @* begin
        stat_nxt = stat_r;
        if (wr_stat) begin
            stat_nxt = stat_r & ~(wdata_i & `TMZ_ST_WMASK);
        end
        // (RL5) pin flag set
        // (RL9) overflow flag set
        stat_nxt = stat_nxt | set_bits;
    end

    // mask register, only implemented bits kept
    always @* begin
        mask_nxt = mask_r;
        if (wr_mask) begin
            mask_nxt = wdata_i & `TMZ_ST_WMASK;
        end
    end

    // one-cycle overflow marker for neighbouring logic
    always @* begin
        ovf_nxt = cnt_wrap;
    end

    // read mux, answered one cycle after the strobe and only then
    always @* begin
        rdata_nxt = 8'h00;
        if (rd_i) begin
            if (hit(addr_i, `TMZ_ADDR_CTRL)) begin
                // (RL8) reads zero in bit zero
                rdata_nxt = ctrl_r & `TMZ_CTRL_WMASK;
            end else if (hit(addr_i, `TMZ_ADDR_CNT_LO)) begin
                // (RL1) low byte read
                rdata_nxt = main_count_r[7:0];
            end else if (hit(addr_i, `TMZ_ADDR_CNT_HI)) begin
                // (RL1) high byte read
                rdata_nxt = main_count_r[15:8];
            end else if (hit(addr_i, `TMZ_ADDR_STAT)) begin
                rdata_nxt = stat_r;
            end else if (hit(addr_i, `TMZ_ADDR_MASK)) begin
                rdata_nxt = mask_r;
            end else begin
                rdata_nxt = 8'h00;
            end
        end
    end

    // state registers
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_r <= `TMZ_CTRL_RST;
            main_count_r <= `TMZ_CNT_RST;
            pre_r <= `TMZ_PRE_RST;
            stat_r <= `TMZ_ST_RST;
            mask_r <= `TMZ_ST_RST;
            rdata_r <= 8'h00;
            ovf_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            main_count_r <= main_count_nxt;
            pre_r <= pre_nxt;
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            rdata_r <= rdata_nxt;
            ovf_r <= ovf_nxt;
        end
    end

    // outputs; irq is a level from registers, held until cleared or masked
    assign rdata_o = rdata_r;
    assign irq_o = |(stat_r & mask_r);
    assign overflow_o = ovf_r;

    // synchronised levels are not needed beyond edge detection
    wire unused_lvl;
    assign unused_lvl = cnt_pin_lvl ^ int_pin_lvl;

endmodule // tmz_timer0

`default_nettype wire

// [tb/tmz_timer0_properties.sv]
/* Port assertions for tmz_timer0.
   Assumes one clock and an async active-high reset. */
`timescale 1ns/100ps
`default_nettype none
module tmz_chk (
    // clock, reset
    input wire logic clk_i,
    input wire logic rst_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    // events
    input wire logic irq_o,
    input wire logic overflow_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [7:0] ctl_r;
    logic [7:0] msk_r;
    // shadows of written control and mask
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctl_r <= 8'h00;
            msk_r <= 8'h00;
        end else if (wr_i && addr_i == 8'h05) begin
            ctl_r <= wdata_i;
        end else if (wr_i && addr_i == 8'h11) begin
            msk_r <= wdata_i & 8'h07;
        end
    end
    // control write, gap, control read
    sequence s_ctl;
        wr_i && addr_i == 8'h05 ##1 !wr_i ##1 rd_i && addr_i == 8'h05;
    endsequence
    // two low-byte reads on internal 1:1
    sequence s_lo2;
        rd_i && addr_i == 8'h0b && ctl_r[5:1] == 5'h10 ##1 rd_i && addr_i == 8'h0b;
    endsequence
    AST_RD_IDLE: assert property (!rd_i |=> !rdata_o) // idle data
        else $error("rdata not zero");
    AST_UNMAP: assert property ( // unmapped
        rd_i && !(addr_i inside {8'h05, 8'h0b, 8'h0c, 8'h10, 8'h11}) |=> !rdata_o)
        else $error("unmapped read");
    AST_CTL_B0: assert property (rd_i && addr_i == 8'h05 |=> !rdata_o[0]) // bit 0
        else $error("control bit 0 set");
    AST_CTL_RB: assert property (s_ctl |=> rdata_o == ($past(wdata_i, 3) & 8'hfe))
        else $error("control readback");
    AST_LO_STEP: assert property (s_lo2 |=> rdata_o == $past(rdata_o) + 8'h01)
        else $error("internal step");
    AST_OVF_ONE: assert property (overflow_o |=> !overflow_o) // one pulse
        else $error("overflow too long");
    AST_OVF_IRQ: assert property (overflow_o && msk_r[0] |-> ##[0:2] irq_o)
        else $error("no irq on overflow");
    AST_IRQ_OFF: assert property (!msk_r && !$past(msk_r) |-> !irq_o) // masked
        else $error("irq while masked");
endmodule // tmz_chk

bind tmz_timer0 tmz_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
    .overflow_o(overflow_o));
`default_nettype wire

// [tb/tmz_pin_model.sv]
/* Far-side driver of the count and interrupt pins.
   Assumes the bench clock on clk_i. */
`timescale 1ns/100ps
`default_nettype none
module tmz_pin_model (
    // bench clock
    input wire logic clk_i,
    // pins
    output var logic cnt_o,
    output var logic int_o
);
    // pins idle low
    initial begin
        cnt_o = 1'b0;
        int_o = 1'b0;
    end
    // four clocks a level, over the two the sync needs
    task automatic set(input logic s, l);
        @(posedge clk_i);
        if (s) int_o <= l;
        else cnt_o <= l;
        repeat (3) @(posedge clk_i);
    endtask
    // n whole pulses on the count pin
    task automatic pulse(input int n);
        repeat (2 * n) set(0, !cnt_o);
    endtask
endmodule // tmz_pin_model
`default_nettype wire

// [tb/tmz_timer0_tb.sv]
/* Register-level tests of tmz_timer0.
   Assumes tmz_pin_model drives both pins. */
`timescale 1ns/100ps
`default_nettype none
module tmz_timer0_tb;
    logic clk_i = 0;
    logic rst_i = 1;
    logic wr_i = 0;
    logic rd_i = 0;
    logic [7:0] addr_i = 0;
    logic [7:0] wdata_i = 0;
    logic [7:0] v, w;
    logic [7:0] cs [2] = '{8'h20, 8'h60};
    wire [7:0] rdata_o;
    wire cp, ip, irq_o, overflow_o;
    int num_errors = 0;
    int checks_done = 0;
    int n;
    int ovf_n = 0;
    always #5 clk_i = ~clk_i;
    // overflow pulses counted
    always @(posedge clk_i) if (overflow_o === 1'b1) ovf_n <= ovf_n + 1;
    tmz_pin_model pm_u (.clk_i(clk_i), .cnt_o(cp), .int_o(ip));
    tmz_timer0 dut_u (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .count_input_pin_i(cp),
        .external_interrupt_pin_i(ip), .irq_o(irq_o), .overflow_o(overflow_o));
    task automatic chk(input string nm, input logic [7:0] s, e);
        checks_done++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1;
        @(posedge clk_i);
        wr_i <= 0;
    endtask
    // two back-to-back reads: w then v
    task automatic rd2(input logic [7:0] a, input bit two);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1;
        @(posedge clk_i);
        if (two) begin
            #1 w = rdata_o;
            @(posedge clk_i);
        end
        rd_i <= 0;
        #1 v = rdata_o;
    endtask
    task automatic rc(input logic [7:0] a, e);
        rd2(a, 0);
        chk($sformatf("reg %h", a), v, e);
    endtask
    // pin change, settle, then read
    task automatic pt(input logic s, l, input logic [7:0] a, e);
        pm_u.set(s, l);
        repeat (3) @(posedge clk_i);
        rc(a, e);
    endtask
    task print_verdict;
        if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 0;
        rc(8'h05, 8'h00); // reset control
        rc(8'h10, 8'h00); // reset status
        rc(8'h0b, 8'h00); // reset count
        wr(8'h05, 8'hff);
        rc(8'h05, 8'hfe); // bit 0 reads zero
        wr(8'h05, 8'h00);
        wr(8'h0b, 8'h34);
        wr(8'h0c, 8'h12);
        rc(8'h0b, 8'h34); // low byte
        rc(8'h0c, 8'h12); // high byte
        rc(8'h20, 8'h00); // unmapped
        // internal source, pin toggling meanwhile
        foreach (cs[i]) begin
            wr(8'h05, cs[i]);
            fork
                pm_u.pulse(1);
                rd2(8'h0b, 1);
            join
            chk("step", v - w, 8'h01); // edge select ignored
        end
        // count pin edge select
        wr(8'h05, 8'h40);
        wr(8'h0b, 8'h00);
        pt(0, 1, 8'h0b, 8'h01); // rising counts
        pt(0, 0, 8'h0b, 8'h01); // falling ignored
        wr(8'h05, 8'h00);
        pt(0, 1, 8'h0b, 8'h01); // rising ignored
        pt(0, 0, 8'h0b, 8'h02); // falling counts
        // every prescale code, 2*ratio-1 edges give one count
        for (n = 0; n < 16; n++) begin
            wr(8'h05, {3'b010, 4'(n), 1'b0});
            wr(8'h0b, 8'h00);
            wr(8'h10, 8'h07);
            pm_u.pulse(n > 7 ? 511 : (2 << n) - 1);
            pt(0, 0, 8'h0b, 8'h01); // ratio
            rc(8'h10, 8'h02); // pin flag
        end
        wr(8'h05, 8'h00);
        wr(8'h11, 8'h01);
        wr(8'h0b, 8'hff);
        wr(8'h0c, 8'h12);
        pm_u.pulse(1);
        rc(8'h0c, 8'h13); // carry
        wr(8'h0c, 8'hff);
        wr(8'h0b, 8'hff);
        wr(8'h10, 8'h07);
        n = ovf_n;
        pm_u.pulse(1);
        // wrap lands on the pulse's last edge, the marker and its tally follow
        repeat (2) @(posedge clk_i);
        chk("ovf", ovf_n - n, 8'h01); // one wrap pulse
        chk("irq", irq_o, 8'h01); // unmasked
        rc(8'h0c, 8'h00); // wrap to zero
        rc(8'h10, 8'h03); // sticky flags
        wr(8'h11, 8'h00);
        repeat (2) @(posedge clk_i);
        chk("irq", irq_o, 8'h00); // masked
        wr(8'h10, 8'h01);
        rc(8'h10, 8'h02); // write one clears
        // interrupt pin edge select
        wr(8'h05, 8'h80);
        wr(8'h10, 8'h07);
        pt(1, 1, 8'h10, 8'h04); // rising sets
        wr(8'h10, 8'h07);
        pt(1, 0, 8'h10, 8'h00); // falling ignored
        wr(8'h05, 8'h00);
        pt(1, 1, 8'h10, 8'h00); // rising ignored
        pt(1, 0, 8'h10, 8'h04); // falling sets
        print_verdict;
    end
    // watchdog, tests need about 40000 cycles
    initial begin
        repeat (80000) @(posedge clk_i);
        num_errors++;
        print_verdict;
    end
endmodule // tmz_timer0_tb
`default_nettype wire
